/* core/bcg_ctrl.sv */
// bus command gating controller: cycle sequencing and command/data-enable gating
//
// Behaviour
// [RULE1] strap high: shared pin is arbitration grant; strap low: command enable
// [RULE2] grant withdrawn: float commands and drop data enable at once
// [RULE3] arbiter withdraws grant only in idle or status state
// [RULE4] arbiter grants the shared bus to one controller at a time
// [RULE5] grant arriving: data enable follows now, commands three edges later
// [RULE6] grant accepted in any state, synchronised as an asynchronous input
// [RULE7] system uses inactive data enable to switch off transceivers
// [RULE8] non-shared: enable falling forces commands and data enable inactive
// [RULE9] non-shared: enable rising restores outputs the cycle calls for
// [RULE10] selected cycle with enable low still needs ready to end
// [RULE11] commands wait for command delay low; control outputs ignore it
// [RULE12] command delay sampled at end of status, then every following edge
// [RULE13] non-shared: command goes active as soon as delay samples low
// [RULE14] shared: command no earlier than the normal shared-bus delay
// [RULE15] ready before command: no command, data enable and direction end normally
// [RULE16] cycle select latched at end of status; low keeps everything inactive
// [RULE17] shared mode delays read and acknowledge commands by one clock
// [RULE18] shared mode delays write commands by two clocks
// [RULE19] halt cycle: no outputs, inputs ignored until next cycle starts
// [RULE20] reset: idle state, commands and data enable off, direction high
`timescale 1ns/1ns
module bcg_ctrl (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic shared_bus_mode_strap_i,
  input wire logic shared_enable_pin_i,
  input wire logic [1:0] status_n_i,
  input wire logic mem_io_i,
  input wire logic cycle_select_i,
  input wire logic command_delay_i,
  input wire logic ready_n_i,
  output logic mem_read_cmd_n_o,
  output logic mem_write_cmd_n_o,
  output logic io_read_cmd_n_o,
  output logic io_write_cmd_n_o,
  output logic irq_ack_cmd_n_o,
  output logic cmd_oe_n_o,
  output logic data_enable_o,
  output logic transfer_direction_o,
  output logic addr_latch_o,
  output logic cascade_enable_o
);

  // ----------------------------------------------------------------
  // reset release and strap capture
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;
  logic strap_q;
  logic strap_d;
  logic strap_done_q;
  logic strap_done_d;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // strap is caught once after release; changing it later has no effect
  always_comb begin
    strap_d = strap_done_q ? strap_q : shared_bus_mode_strap_i;
    strap_done_d = 1'b1;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ----------------------------------------------------------------
  // shared enable pin: grant or command enable
  // ----------------------------------------------------------------
  logic pin_s;
  logic arbitration_grant_n;
  logic command_enable_async;
  logic grant_done;
  logic cmd_gate;
  logic den_gate;

  bcg_sync u_pin_sync (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n),
    .async_i (shared_enable_pin_i),
    .sync_o (pin_s)
  ); // [RULE6]

  assign arbitration_grant_n = strap_q ? pin_s : 1'b1; // [RULE1]
  assign command_enable_async = strap_q ? 1'b1 : pin_s; // [RULE1]

  bcg_grant_timer u_grant_timer (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n),
    .grant_low_i (!arbitration_grant_n),
    .done_o (grant_done)
  ); // [RULE5]

  // level gating, so a change acts on the very next output edge
  assign cmd_gate = strap_q ? grant_done : command_enable_async; // [RULE5] [RULE8] [RULE9]
  assign den_gate = strap_q ? !arbitration_grant_n : command_enable_async; // [RULE2] [RULE8]

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  bcg_pkg::bcg_state_e state_q;
  bcg_pkg::bcg_state_e state_d;
  logic [2:0] code_q;
  logic [2:0] code_d;
  logic cycle_select_latched_q;
  logic cycle_select_latched_d;
  logic [1:0] age_q;
  logic [1:0] age_d;
  logic delay_ok_q;
  logic delay_ok_d;
  logic status_active;
  logic [2:0] status_code;

  assign status_active = (status_n_i != bcg_pkg::BCG_STATUS_IDLE);
  assign status_code = {mem_io_i, status_n_i};

  always_comb begin
    state_d = state_q;
    code_d = code_q;
    cycle_select_latched_d = cycle_select_latched_q;
    age_d = age_q;
    delay_ok_d = delay_ok_q;
    unique case (state_q)
      bcg_pkg::BCG_IDLE: begin
        if (status_active) begin
          code_d = status_code;
          state_d = (status_code == bcg_pkg::BCG_CYC_HALT) ? bcg_pkg::BCG_HALT
                                                           : bcg_pkg::BCG_STATUS;
        end
      end
      bcg_pkg::BCG_STATUS: begin
        cycle_select_latched_d = cycle_select_i; // [RULE16]
        delay_ok_d = !command_delay_i; // [RULE12]
        age_d = 2'h0;
        // deselected cycles drop to idle and ignore delay, enable and ready
        state_d = cycle_select_i ? bcg_pkg::BCG_CMD : bcg_pkg::BCG_IDLE; // [RULE16]
      end
      bcg_pkg::BCG_CMD: begin
        age_d = (age_q == bcg_pkg::BCG_AGE_MAX) ? age_q : 2'(age_q + 2'h1);
        if (!command_delay_i) begin
          delay_ok_d = 1'b1; // [RULE12]
        end
        // only ready ends a selected cycle, whatever the enable does
        if (!ready_n_i) begin // [RULE10] [RULE15]
          delay_ok_d = 1'b0;
          if (status_active) begin
            code_d = status_code;
            state_d = (status_code == bcg_pkg::BCG_CYC_HALT) ? bcg_pkg::BCG_HALT
                                                             : bcg_pkg::BCG_STATUS;
          end else begin
            state_d = bcg_pkg::BCG_IDLE;
          end
        end
      end
      bcg_pkg::BCG_HALT: begin
        // every input is ignored until a non-halt status arrives
        if (status_active && (status_code != bcg_pkg::BCG_CYC_HALT)) begin // [RULE19]
          code_d = status_code;
          state_d = bcg_pkg::BCG_STATUS;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= bcg_pkg::BCG_IDLE; // [RULE20]
      code_q <= bcg_pkg::BCG_CYC_HALT;
      cycle_select_latched_q <= 1'b0;
      age_q <= 2'h0;
      delay_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      code_q <= code_d;
      cycle_select_latched_q <= cycle_select_latched_d;
      age_q <= age_d;
      delay_ok_q <= delay_ok_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, computed from next state so they line up with it
  // ----------------------------------------------------------------
  logic [4:0] cmd_n_q;
  logic [4:0] cmd_n_d;
  logic cmd_oe_n_q;
  logic cmd_oe_n_d;
  logic den_q;
  logic den_d;
  logic dir_q;
  logic dir_d;
  logic ale_q;
  logic ale_d;
  logic mce_q;
  logic mce_d;
  logic in_cmd_d;

  always_comb begin
    in_cmd_d = (state_d == bcg_pkg::BCG_CMD);
    cmd_n_d = bcg_pkg::BCG_CMD_NONE;
    if (in_cmd_d && delay_ok_d && cmd_gate &&
        (age_d >= bcg_pkg::cmd_delay(code_d, strap_q))) begin // [RULE11] [RULE13] [RULE14] [RULE17] [RULE18]
      cmd_n_d = bcg_pkg::cmd_vector(code_d);
    end
    cmd_oe_n_d = strap_q && pin_s; // [RULE2] [RULE5]
    den_d = 1'b0;
    if (in_cmd_d && den_gate) begin
      if (bcg_pkg::is_read(code_d)) begin
        den_d = 1'b1;
      end else if (bcg_pkg::is_write(code_d)) begin
        den_d = !strap_q || (age_d >= bcg_pkg::BCG_DEN_WRITE_SHARED_DELAY);
      end
    end else if ((state_d == bcg_pkg::BCG_STATUS) && !strap_q && den_gate &&
                 bcg_pkg::is_write(code_d)) begin
      // write data enable leads the select sample; a deselect drops it
      den_d = 1'b1;
    end
    dir_d = !(in_cmd_d && bcg_pkg::is_read(code_d)); // [RULE15] [RULE16]
    ale_d = (state_d == bcg_pkg::BCG_STATUS);
    mce_d = (code_d == bcg_pkg::BCG_CYC_IRQ_ACK) &&
            ((state_d == bcg_pkg::BCG_STATUS) || (in_cmd_d && (age_d == 2'h0)));
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_n_q <= bcg_pkg::BCG_CMD_NONE; // [RULE20]
      cmd_oe_n_q <= 1'b0;
      den_q <= 1'b0;
      dir_q <= 1'b1;
      ale_q <= 1'b0;
      mce_q <= 1'b0;
    end else begin
      cmd_n_q <= cmd_n_d;
      cmd_oe_n_q <= cmd_oe_n_d;
      den_q <= den_d;
      dir_q <= dir_d;
      ale_q <= ale_d;
      mce_q <= mce_d;
    end
  end

  assign mem_read_cmd_n_o = cmd_n_q[bcg_pkg::BCG_CMD_MEM_READ];
  assign mem_write_cmd_n_o = cmd_n_q[bcg_pkg::BCG_CMD_MEM_WRITE];
  assign io_read_cmd_n_o = cmd_n_q[bcg_pkg::BCG_CMD_IO_READ];
  assign io_write_cmd_n_o = cmd_n_q[bcg_pkg::BCG_CMD_IO_WRITE];
  assign irq_ack_cmd_n_o = cmd_n_q[bcg_pkg::BCG_CMD_IRQ_ACK];
  assign cmd_oe_n_o = cmd_oe_n_q;
  assign data_enable_o = den_q;
  assign transfer_direction_o = dir_q;
  assign addr_latch_o = ale_q;
  assign cascade_enable_o = mce_q;

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  logic cmd_idle;
  assign cmd_idle = (cmd_n_q == bcg_pkg::BCG_CMD_NONE);

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  AST_GRANT_FLOAT: assert property ( // [RULE2]
    strap_q && $rose(pin_s) |=> cmd_oe_n_o && !data_enable_o)
    else $error("grant withdrawn but commands not floated");

  AST_GRANT_DELAY: assert property ( // [RULE5]
    strap_q && $fell(pin_s) |-> cmd_idle [*3])
    else $error("command active before three edges of grant");

  AST_ENABLE_OFF: assert property ( // [RULE8]
    !strap_q && $fell(pin_s) |=> cmd_idle && !data_enable_o)
    else $error("enable low but outputs still active");

  AST_DELAY_GATES: assert property ( // [RULE11]
    !cmd_idle |-> delay_ok_q && (state_q == bcg_pkg::BCG_CMD))
    else $error("command active without command delay low");

  AST_DESELECT: assert property ( // [RULE16]
    (state_q == bcg_pkg::BCG_STATUS) && !cycle_select_i |=>
      (cmd_idle && !data_enable_o && transfer_direction_o) [*2])
    else $error("deselected cycle drove outputs");

  AST_READ_SHARED: assert property ( // [RULE17]
    strap_q && (state_q == bcg_pkg::BCG_CMD) && (age_q == 2'h0) |-> cmd_idle)
    else $error("shared read command too early");

  AST_WRITE_SHARED: assert property ( // [RULE18]
    strap_q && (state_q == bcg_pkg::BCG_CMD) && bcg_pkg::is_write(code_q) &&
      (age_q < bcg_pkg::BCG_WRITE_SHARED_DELAY) |-> cmd_idle)
    else $error("shared write command too early");

  AST_HALT_QUIET: assert property ( // [RULE19]
    state_q == bcg_pkg::BCG_HALT |-> cmd_idle && !data_enable_o && !addr_latch_o)
    else $error("halt cycle drove an output");

  AST_READY_END: assert property ( // [RULE15]
    (state_q == bcg_pkg::BCG_CMD) && !ready_n_i |=> cmd_idle && transfer_direction_o)
    else $error("ready did not end command and direction");

  AST_READY_NEEDED: assert property ( // [RULE10]
    (state_q == bcg_pkg::BCG_CMD) && ready_n_i |=> state_q == bcg_pkg::BCG_CMD)
    else $error("cycle ended without ready");

  COV_READ_CMD: cover property (!mem_read_cmd_n_o);
  COV_WRITE_CMD: cover property (strap_q && !io_write_cmd_n_o);
  COV_NO_CMD_END: cover property (
    (state_q == bcg_pkg::BCG_CMD) && !delay_ok_q && !ready_n_i);
  COV_HALT: cover property (state_q == bcg_pkg::BCG_HALT);

endmodule

/* core/bcg_grant_timer.sv */
// counts clock edges since the arbitration grant went active
`timescale 1ns/1ns
module bcg_grant_timer (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic grant_low_i,
  output logic done_o
);

  // ----------------------------------------------------------------
  // saturating edge counter
  // ----------------------------------------------------------------
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic done_q;
  logic done_d;

  always_comb begin
    count_d = 2'h0;
    if (grant_low_i) begin
      count_d = (count_q == bcg_pkg::BCG_AGE_MAX) ? count_q : 2'(count_q + 2'h1);
    end
    // registered done plus registered command output make up the last edge
    done_d = grant_low_i && (count_d >= 2'(bcg_pkg::BCG_GRANT_EDGES - 2'h1));
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule

/* core/bcg_pkg.sv */
// constants, types and decode helpers shared by the bus command gating design
package bcg_pkg;

  // ----------------------------------------------------------------
  // bus states and status decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BCG_IDLE,
    BCG_STATUS,
    BCG_CMD,
    BCG_HALT
  } bcg_state_e;

  localparam logic [1:0] BCG_STATUS_IDLE = 2'h3;
  localparam int unsigned BCG_CODE_W = 3;

  // cycle codes as {mem_io, status1_n, status0_n}
  localparam logic [2:0] BCG_CYC_IRQ_ACK = 3'h0;
  localparam logic [2:0] BCG_CYC_IO_READ = 3'h1;
  localparam logic [2:0] BCG_CYC_IO_WRITE = 3'h2;
  localparam logic [2:0] BCG_CYC_HALT = 3'h4;
  localparam logic [2:0] BCG_CYC_MEM_READ = 3'h5;
  localparam logic [2:0] BCG_CYC_MEM_WRITE = 3'h6;

  // ----------------------------------------------------------------
  // command vector layout (active low outputs)
  // ----------------------------------------------------------------
  localparam int unsigned BCG_CMD_W = 5;
  localparam int unsigned BCG_CMD_MEM_READ = 0;
  localparam int unsigned BCG_CMD_MEM_WRITE = 1;
  localparam int unsigned BCG_CMD_IO_READ = 2;
  localparam int unsigned BCG_CMD_IO_WRITE = 3;
  localparam int unsigned BCG_CMD_IRQ_ACK = 4;
  localparam logic [4:0] BCG_CMD_NONE = 5'h1F;

  // ----------------------------------------------------------------
  // timing counts in clock edges
  // ----------------------------------------------------------------
  localparam int unsigned BCG_AGE_W = 2;
  localparam logic [1:0] BCG_AGE_MAX = 2'h3;
  localparam logic [1:0] BCG_GRANT_EDGES = 2'h3;
  localparam logic [1:0] BCG_READ_SHARED_DELAY = 2'h1;
  localparam logic [1:0] BCG_WRITE_SHARED_DELAY = 2'h2;
  localparam logic [1:0] BCG_DEN_WRITE_SHARED_DELAY = 2'h1;
  localparam int unsigned BCG_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_read(input logic [2:0] code);
    is_read = (code == BCG_CYC_IRQ_ACK) || (code == BCG_CYC_IO_READ) ||
              (code == BCG_CYC_MEM_READ);
  endfunction

  function automatic logic is_write(input logic [2:0] code);
    is_write = (code == BCG_CYC_IO_WRITE) || (code == BCG_CYC_MEM_WRITE);
  endfunction

  function automatic logic [1:0] cmd_delay(input logic [2:0] code, input logic shared);
    if (!shared) begin
      cmd_delay = 2'h0;
    end else if (is_write(code)) begin
      cmd_delay = BCG_WRITE_SHARED_DELAY;
    end else begin
      cmd_delay = BCG_READ_SHARED_DELAY;
    end
  endfunction

  function automatic logic [4:0] cmd_vector(input logic [2:0] code);
    logic [4:0] v;
    v = BCG_CMD_NONE;
    unique case (code)
      BCG_CYC_MEM_READ: v[BCG_CMD_MEM_READ] = 1'b0;
      BCG_CYC_MEM_WRITE: v[BCG_CMD_MEM_WRITE] = 1'b0;
      BCG_CYC_IO_READ: v[BCG_CMD_IO_READ] = 1'b0;
      BCG_CYC_IO_WRITE: v[BCG_CMD_IO_WRITE] = 1'b0;
      BCG_CYC_IRQ_ACK: v[BCG_CMD_IRQ_ACK] = 1'b0;
      default: v = BCG_CMD_NONE;
    endcase
    cmd_vector = v;
  endfunction

endpackage

/* core/bcg_sync.sv */
// two flip-flop synchroniser for the shared enable pin
`timescale 1ns/1ns
module bcg_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);

  // ----------------------------------------------------------------
  // stages: the first stage feeds only the second
  // ----------------------------------------------------------------
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  // resets high: command enable active and grant withdrawn
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

/* sim/bcg_partner_model.sv */
// far-side model: processor status lines, address decoder and bus arbiter
`timescale 1ns/1ns
module bcg_partner_model (
  input wire logic mclk_i,
  output logic [1:0] status_n_o,
  output logic mem_io_o,
  output logic cycle_select_o,
  output logic command_delay_o,
  output logic ready_n_o,
  output logic shared_enable_pin_o
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    status_n_o = 2'h3;
    mem_io_o = 1'b0;
    cycle_select_o = 1'b0;
    command_delay_o = 1'b1;
    ready_n_o = 1'b1;
    shared_enable_pin_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // one bus cycle of eleven clocks
  // ----------------------------------------------------------------
  // k: delay sampled high k times; r: ready sampled r+1 edges after status
  // stale qualifiers toggle once released, so nothing leans on an old value
  task automatic run(input logic [2:0] code, input logic sel, input int k, input int r);
    int i;
    @(posedge mclk_i);
    #2;
    status_n_o = code[1:0];
    mem_io_o = code[2];
    cycle_select_o = sel;
    command_delay_o = (k > 0);
    for (i = 1; i <= 10; i++) begin
      @(posedge mclk_i);
      #2;
      status_n_o = 2'h3;
      mem_io_o = ~mem_io_o;
      if (i > 1) begin
        cycle_select_o = ~cycle_select_o;
      end
      command_delay_o = (i <= k);
      ready_n_o = (i != 1 + r);
    end
  endtask

  // ----------------------------------------------------------------
  // arbiter grant
  // ----------------------------------------------------------------
  // called between cycles while the bus is idle, and once in the middle of a cycle to raise the enable
  // this controller is the only one ever granted
  task automatic set_pin(input logic v);
    @(posedge mclk_i);
    #2;
    shared_enable_pin_o = v;
  endtask
endmodule

/* sim/bus_command_gating_inputs_tb.sv */
// self-checking testbench for the bus command gating controller
`timescale 1ns/1ns
module bus_command_gating_inputs_tb;
  // ----------------------------------------------------------------
  // clock, reset and wiring
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b0;
  logic [1:0] status_n;
  logic mem_io, sel, cdly, rdy_n, pin;
  logic mr_n, mw_n, ior_n, iow_n, ia_n, oe_n, data_enable, dir, ale, cascade_enable;
  logic [4:0] cmd_n;
  logic [17:0] notes[$];
  logic [31:0] seed = 32'h9EE87D8A;
  logic [2:0] codes [5] = '{bcg_pkg::BCG_CYC_MEM_READ, bcg_pkg::BCG_CYC_MEM_WRITE,
    bcg_pkg::BCG_CYC_IO_READ, bcg_pkg::BCG_CYC_IO_WRITE, bcg_pkg::BCG_CYC_IRQ_ACK};
  int miscompares = 0;
  int cmp_count = 0;

  always #25 mclk = ~mclk;
  assign cmd_n = {ia_n, iow_n, ior_n, mw_n, mr_n};

  bcg_ctrl u_bcg_ctrl (.mclk_i(mclk), .resetn_i(resetn), .shared_bus_mode_strap_i(strap),
    .shared_enable_pin_i(pin), .status_n_i(status_n), .mem_io_i(mem_io),
    .cycle_select_i(sel), .command_delay_i(cdly), .ready_n_i(rdy_n),
    .mem_read_cmd_n_o(mr_n), .mem_write_cmd_n_o(mw_n), .io_read_cmd_n_o(ior_n),
    .io_write_cmd_n_o(iow_n), .irq_ack_cmd_n_o(ia_n), .cmd_oe_n_o(oe_n),
    .data_enable_o(data_enable), .transfer_direction_o(dir), .addr_latch_o(ale),
    .cascade_enable_o(cascade_enable));

  bcg_partner_model u_bcg_partner_model (.mclk_i(mclk), .status_n_o(status_n),
    .mem_io_o(mem_io), .cycle_select_o(sel), .command_delay_o(cdly), .ready_n_o(rdy_n),
    .shared_enable_pin_o(pin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // note: {command vector, first edge, width, dir low, den seen, float seen,
  //        cascade on first edge after strobe, strobe or cascade lingering}
  // late: edge index at which the enable takes hold, 15 = never in this cycle
  function automatic logic [17:0] exp_note(input logic [2:0] code, input logic s,
                                           input int k, input int r, input int late);
    logic [4:0] v;
    logic rd;
    logic en;
    int sd;
    int o;
    int w;
    v = bcg_pkg::BCG_CMD_NONE;
    rd = (code == bcg_pkg::BCG_CYC_MEM_READ) || (code == bcg_pkg::BCG_CYC_IO_READ) ||
         (code == bcg_pkg::BCG_CYC_IRQ_ACK);
    case (code)
      bcg_pkg::BCG_CYC_MEM_READ: v[bcg_pkg::BCG_CMD_MEM_READ] = 1'b0;
      bcg_pkg::BCG_CYC_MEM_WRITE: v[bcg_pkg::BCG_CMD_MEM_WRITE] = 1'b0;
      bcg_pkg::BCG_CYC_IO_READ: v[bcg_pkg::BCG_CMD_IO_READ] = 1'b0;
      bcg_pkg::BCG_CYC_IO_WRITE: v[bcg_pkg::BCG_CMD_IO_WRITE] = 1'b0;
      default: v[bcg_pkg::BCG_CMD_IRQ_ACK] = 1'b0;
    endcase
    sd = !strap ? 0 : (rd ? 1 : 2);
    o = 1 + ((k > sd) ? k : sd);
    if (late > o) begin
      o = late;
    end
    en = s && (late < 15);
    w = (en && (1 + r > o)) ? 1 + r - o : 0;
    if (w == 0) begin
      v = bcg_pkg::BCG_CMD_NONE;
      o = 0;
    end
    return {v, 4'(o), 4'(w), s && rd, en, strap && (late == 15),
            s && (code == bcg_pkg::BCG_CYC_IRQ_ACK), 1'b0};
  endfunction

  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    cmp_count++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic cyc(input logic [2:0] code, input logic s, input int k, input int r,
                     input int late);
    notes.push_back(exp_note(code, s, k, r, late));
    u_bcg_partner_model.run(code, s, k, r);
  endtask

  task automatic do_reset(input logic mode, input logic p);
    u_bcg_partner_model.set_pin(p);
    resetn = 1'b0;
    strap = mode;
    repeat (12) @(posedge mclk);
    #2;
    resetn = 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(18'({cmd_n, data_enable, dir, oe_n, cascade_enable}), 18'({bcg_pkg::BCG_CMD_NONE, 4'h4}));
  endtask

  task automatic rand_cycles(input int n);
    logic [31:0] r;
    repeat (n) begin
      r = xs();
      cyc(codes[r % 5], r[8:7] != 2'h0, int'(r[12:11]), 2 + int'(r[17:16]), 0);
    end
  endtask

  task automatic end_sim();
    if (notes.size() != 0) begin
      miscompares++;
    end
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // output monitor: eight settled samples after each address strobe
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [17:0] got;
    n = -1;
    got = 18'h0;
    forever begin
      @(negedge mclk);
      if (!resetn) begin
        n = -1;
      end else if (n < 0) begin
        if (ale === 1'b1) begin
          n = 0;
          got = {bcg_pkg::BCG_CMD_NONE, 13'h0};
        end
      end else begin
        n++;
        if (cmd_n !== bcg_pkg::BCG_CMD_NONE) begin
          if (got[12:9] == 4'h0) begin
            got[17:13] = cmd_n;
            got[12:9] = 4'(n);
          end
          got[8:5] = got[8:5] + 4'h1;
        end
        got[4] = got[4] | (dir === 1'b0);
        // den is what turns the transceivers off the shared data bus
        got[3] = got[3] | (data_enable === 1'b1);
        got[2] = got[2] | (oe_n === 1'b1);
        // cascade enable outlasts the strobe by one edge; neither may linger
        got[1] = got[1] | ((n == 1) && (cascade_enable === 1'b1));
        got[0] = got[0] | ((n > 1) && ((cascade_enable !== 1'b0) || (ale !== 1'b0)));
        if (n == 8) begin
          n = -1;
          if (notes.size() == 0) begin
            chk(got, 18'h3FFFF);
          end else begin
            chk(got, notes.pop_front());
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
    end_sim();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int i;
    do_reset(1'b0, 1'b1);
    for (i = 0; i < 5; i++) begin
      cyc(codes[i], 1'b1, 0, 2, 0);
    end
    cyc(bcg_pkg::BCG_CYC_MEM_WRITE, 1'b0, 0, 3, 0);
    cyc(bcg_pkg::BCG_CYC_IO_READ, 1'b0, 1, 2, 0);
    u_bcg_partner_model.run(bcg_pkg::BCG_CYC_HALT, 1'b1, 0, 2);
    cyc(bcg_pkg::BCG_CYC_IO_READ, 1'b1, 2, 4, 0);
    cyc(bcg_pkg::BCG_CYC_MEM_READ, 1'b1, 3, 2, 0);
    $display("test non_shared done");
    u_bcg_partner_model.set_pin(1'b0);
    repeat (3) @(posedge mclk);
    cyc(bcg_pkg::BCG_CYC_MEM_WRITE, 1'b1, 0, 3, 15);
    fork
      cyc(bcg_pkg::BCG_CYC_MEM_READ, 1'b1, 0, 5, 3);
      begin
        @(posedge mclk);
        u_bcg_partner_model.set_pin(1'b1);
      end
    join
    rand_cycles(12);
    $display("test enable done");
    do_reset(1'b1, 1'b0);
    for (i = 0; i < 5; i++) begin
      cyc(codes[i], 1'b1, 0, 3, 0);
    end
    cyc(bcg_pkg::BCG_CYC_MEM_WRITE, 1'b1, 3, 5, 0);
    u_bcg_partner_model.set_pin(1'b1);
    repeat (3) @(posedge mclk);
    cyc(bcg_pkg::BCG_CYC_IO_WRITE, 1'b1, 0, 3, 15);
    u_bcg_partner_model.set_pin(1'b0);
    repeat (4) @(posedge mclk);
    cyc(bcg_pkg::BCG_CYC_IO_WRITE, 1'b1, 0, 3, 0);
    rand_cycles(12);
    $display("test shared done");
    end_sim();
  end
endmodule
